/* File: bench/host_model.sv */
// host that reads and writes the holding registers over the strobe port
// assumes read data and refusal pulse stand in the cycle after the strobe
module host_model (
	input  wire logic        i_clk,
	input  wire logic [15:0] i_rdata,
	input  wire logic        i_refused,
	output logic      [15:0] o_addr,
	output logic      [15:0] o_wdata,
	output logic             o_wr,
	output logic             o_rd
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************************************
	// bus tasks
	// ****************************************************************
	initial begin
		o_addr = 16'h0000;
		o_wdata = 16'h0000;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end

	// released data lines carry inverted junk so no stale value passes for a real one
	task automatic wr16(input logic [15:0] a, input logic [15:0] d, output logic refused);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_wdata <= ~d;
		#1;
		refused = i_refused;
	endtask

	// high word first, low word in the very next cycle
	task automatic wr32(input logic [15:0] a, input logic [31:0] d, output logic refused);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d[31:16];
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_addr <= a + 16'h0001;
		o_wdata <= d[15:0];
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_wdata <= ~d[15:0];
		#1;
		refused = i_refused;
	endtask

	task automatic rd16(input logic [15:0] a, output logic [15:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		#1;
		d = i_rdata;
	endtask
endmodule

/* File: bench/motor2_regs_properties.sv */
// concurrent checks on the ports of the second motor parameter bank
// assumes one clock and a synchronous active-high reset; bound to the design module
module motor2_regs_checker (
	input wire logic        i_sys_clk,
	input wire logic        i_srst,
	input wire logic [15:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic        o_wr_refused,
	input wire logic [15:0] o_thermal_level,
	input wire logic [1:0]  o_thermal_curve,
	input wire logic [1:0]  o_param_source,
	input wire logic [31:0] o_speed_response,
	input wire logic [15:0] o_zero_hz_limit,
	input wire logic [4:0]  o_capacity,
	input wire logic [2:0]  o_pole_code,
	input wire logic [31:0] o_active_primary_res,
	input wire logic [31:0] o_active_inertia,
	input wire logic [15:0] o_pi_prop_gain,
	input wire logic [15:0] o_pi_integral_gain,
	input wire logic [15:0] o_p_prop_gain,
	input wire logic [7:0]  o_startup_boost,
	input wire logic [31:0] o_accel_time1,
	input wire logic [31:0] o_decel_time1
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************************************
	// properties
	// ****************************************************************
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_srst);

	sequence s_hi_word(a);
		i_wr && i_addr == a;
	endsequence
	sequence s_lo_word(a, lim);
		i_wr && i_addr == a && {$past(i_wdata), i_wdata} inside {[32'h0000_0001:lim]};
	endsequence
	property p_split(a, lim, v);
		s_hi_word(a) ##1 s_lo_word(a + 16'h0001, lim) |=> v == {$past(i_wdata, 2), $past(i_wdata)};
	endproperty

	AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 16'h0000)
		else $error("read data not zero outside a read answer");
	AST_RD_UNMAPPED: assert property (i_rd && i_addr inside {[16'h2508:16'h2514], [16'h2549:16'h3102],
		[16'h230E:16'h2501]} |=> o_rdata == 16'h0000)
		else $error("unused address read not zero");
	AST_THERMAL_TAKE: assert property (i_wr && i_addr == 16'h230C && i_wdata inside {[16'h00C8:16'h03E8]}
		|=> o_thermal_level == $past(i_wdata) && !o_wr_refused)
		else $error("legal thermal write not taken");
	AST_THERMAL_REFUSE: assert property (i_wr && i_addr == 16'h230C && !(i_wdata inside {[16'h00C8:16'h03E8]})
		|=> o_wr_refused && $stable(o_thermal_level))
		else $error("illegal thermal write not refused");
	AST_CODES: assert property (o_thermal_curve <= 2'h2 && o_pole_code <= 3'h4 && o_capacity <= 5'h1A)
		else $error("selector code out of range");
	AST_SETTINGS: assert property (o_param_source <= 2'h2 && o_zero_hz_limit <= 16'h03E8
		&& o_speed_response inside {[32'h0000_0001:32'h0001_3880]})
		else $error("source code, zero-hz limit or speed response out of range");
	AST_CAP_UNUSED: assert property (!(o_capacity inside {5'h01, 5'h03, 5'h05, 5'h08, 5'h0A}))
		else $error("unused capacity code stored");
	AST_GAINS: assert property (o_pi_prop_gain <= 16'h2710 && o_pi_integral_gain <= 16'h2710
		&& o_p_prop_gain <= 16'h03E8 && o_startup_boost <= 8'h32)
		else $error("gain or boost out of range");
	AST_CONSTS: assert property (o_active_primary_res inside {[32'h0000_0001:32'h0000_FFFA]}
		&& o_active_inertia inside {[32'h0000_0001:32'h0098_9298]})
		else $error("motor constant out of range");
	AST_ACCEL_SPLIT: assert property (p_split(16'h3103, 32'h0005_7E40, o_accel_time1))
		else $error("accel time pair not committed");
	AST_DECEL_SPLIT: assert property (p_split(16'h3105, 32'h0005_7E40, o_decel_time1))
		else $error("decel time pair not committed");
endmodule

bind second_motor_param_regs motor2_regs_checker motor2_regs_checker_inst (
	.i_sys_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_wr_refused, .o_thermal_level,
	.o_thermal_curve, .o_capacity, .o_pole_code, .o_active_primary_res, .o_active_inertia, .o_pi_prop_gain,
	.o_pi_integral_gain, .o_p_prop_gain, .o_startup_boost, .o_accel_time1, .o_decel_time1, .o_param_source,
	.o_speed_response, .o_zero_hz_limit
);

/* File: bench/second_motor_param_regs_tb_top.sv */
// self-checking bench for the second motor parameter bank
// assumes the host model and the bound checker are compiled first
module second_motor_param_regs_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************************************
	// set-up
	// ****************************************************************
	logic        i_sys_clk = 1'b0;
	logic        i_srst    = 1'b1;
	logic [15:0] addr, wdata, rdata, rv;
	logic        wr, rd, refused, flag;
	logic [31:0] accel, decel, act_r1, act_j, act_r2, act_l, act_io, spd;
	logic [1:0]  src;
	int          error_cnt = 0;
	int          cmp_count = 0;

	localparam logic [15:0] S_ADDR [17] = '{16'h230C, 16'h230C, 16'h230D, 16'h2502, 16'h2503, 16'h2503, 16'h2503,
		16'h2503, 16'h2503, 16'h2503, 16'h2504, 16'h253D, 16'h253E, 16'h253F, 16'h2548, 16'h2507, 16'h2547};
	localparam logic [15:0] S_GOOD [17] = '{16'h03E8, 16'h00C8, 16'h0002, 16'h0002, 16'h001A, 16'h0000, 16'h0002,
		16'h0007, 16'h0009, 16'h001A, 16'h0004, 16'h2710, 16'h2710, 16'h03E8, 16'h0032, 16'h00FF, 16'h03E8};
	localparam logic [15:0] S_BAD [17] = '{16'h03E9, 16'h00C7, 16'h0003, 16'h0003, 16'h0001, 16'h0003, 16'h0005,
		16'h0008, 16'h000A, 16'h001B, 16'h0005, 16'h2711, 16'h2711, 16'h03E9, 16'h0033, 16'h0100, 16'h03E9};
	localparam logic [15:0] W_ADDR [12] = '{16'h3103, 16'h3105, 16'h251D, 16'h252C, 16'h2515, 16'h2519, 16'h2505,
		16'h2517, 16'h251B, 16'h2526, 16'h2528, 16'h252A};
	localparam logic [31:0] W_GOOD [12] = '{32'h0005_7E40, 32'h0000_0001, 32'h0098_9298, 32'h0000_0001,
		32'h0000_FFFA, 32'h0000_0001, 32'h0001_3880, 32'h0000_FFFA, 32'h0000_FFFA, 32'h0000_0002,
		32'h0000_0003, 32'h0000_0004};
	localparam logic [31:0] W_BAD [12] = '{32'h0005_7E41, 32'h0000_0000, 32'h0098_9299, 32'h0000_0000,
		32'h0000_FFFB, 32'h0001_0000, 32'h0001_3881, 32'h0000_0000, 32'h0000_FFFB, 32'h0000_0000,
		32'h0000_FFFB, 32'h0001_0000};
	localparam logic [15:0] U_ADDR [5] = '{16'h2508, 16'h230E, 16'h2549, 16'h3102, 16'h2278};

	always #5 i_sys_clk = ~i_sys_clk;

	second_motor_param_regs second_motor_param_regs_inst (
		.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .o_wr_refused(refused), .o_thermal_level(), .o_thermal_curve(), .o_param_source(src),
		.o_capacity(), .o_pole_code(), .o_speed_response(spd), .o_stabilization(), .o_active_primary_res(act_r1),
		.o_active_secondary_res(act_r2), .o_active_inductance(act_l), .o_active_noload_current(act_io),
		.o_active_inertia(act_j),
		.o_pi_prop_gain(), .o_pi_integral_gain(), .o_p_prop_gain(), .o_zero_hz_limit(), .o_startup_boost(),
		.o_accel_time1(accel), .o_decel_time1(decel)
	);

	host_model host_model_inst (
		.i_clk(i_sys_clk), .i_rdata(rdata), .i_refused(refused), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
		.o_rd(rd)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out;
		if (error_cnt == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		repeat (12) @(posedge i_sys_clk);
		i_srst <= 1'b0;
		host_model_inst.rd16(16'h230C, rv);
		check(32'(rv), 32'h0000_00C8);
		host_model_inst.rd16(16'h3104, rv);
		check(32'(rv), 32'h0000_0001);
		for (int k = 0; k < 17; k++) begin
			host_model_inst.wr16(S_ADDR[k], S_GOOD[k], flag);
			check(32'(flag), 32'h0);
			host_model_inst.wr16(S_ADDR[k], S_BAD[k], flag);
			check(32'(flag), 32'h1);
			host_model_inst.rd16(S_ADDR[k], rv);
			check(32'(rv), 32'(S_GOOD[k]));
		end
		for (int k = 0; k < 12; k++) begin
			host_model_inst.wr32(W_ADDR[k], W_GOOD[k], flag);
			check(32'(flag), 32'h0);
			host_model_inst.wr32(W_ADDR[k], W_BAD[k], flag);
			check(32'(flag), 32'h1);
			host_model_inst.rd16(W_ADDR[k], rv);
			check(32'(rv), 32'(W_GOOD[k][31:16]));
			host_model_inst.rd16(W_ADDR[k] + 16'h0001, rv);
			check(32'(rv), 32'(W_GOOD[k][15:0]));
		end
		check(accel, 32'h0005_7E40);
		check(decel, 32'h0000_0001);
		check(spd, 32'h0001_3880);
		// manual set 100 and 9999000, tuned set 200 and 1
		host_model_inst.wr32(16'h2515, 32'h0000_0064, flag);
		host_model_inst.wr32(16'h2524, 32'h0000_00C8, flag);
		for (int s = 0; s < 4; s++) begin
			host_model_inst.wr16(16'h2502, 16'(s % 3), flag);
			@(posedge i_sys_clk);
			#1;
			check(act_r1, (s % 3 == 0) ? 32'h0000_0064 : 32'h0000_00C8);
			check(act_j, (s % 3 == 0) ? 32'h0098_9298 : 32'h0000_0001);
			check(32'(src), 32'(s % 3));
			check(act_r2, (s % 3 == 0) ? 32'h0000_FFFA : 32'h0000_0002);
			check(act_l, (s % 3 == 0) ? 32'h0000_0001 : 32'h0000_0003);
			check(act_io, (s % 3 == 0) ? 32'h0000_FFFA : 32'h0000_0004);
		end
		for (int k = 0; k < 5; k++) begin
			host_model_inst.wr16(U_ADDR[k], 16'hFFFF, flag);
			check(32'(flag), 32'h0);
			host_model_inst.rd16(U_ADDR[k], rv);
			check(32'(rv), 32'h0);
		end
		host_model_inst.rd16(16'h2546, rv);
		check(32'(rv), 32'h0);
		@(posedge i_sys_clk);
		i_srst <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		i_srst <= 1'b0;
		host_model_inst.rd16(16'h230C, rv);
		check(32'(rv), 32'h0000_00C8);
		close_out();
	end

	initial begin
		repeat (20000) @(posedge i_sys_clk);
		error_cnt++;
		close_out();
	end
endmodule

/* File: rtl/motor2_regs_map.svh */
// register offsets, value limits and reset values of the second motor parameter bank
// assumes 16-bit register addresses and 16-bit data
`ifndef MOTOR2_REGS_MAP_SVH
`define MOTOR2_REGS_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFF_M2_THERMAL_LEVEL           16'h230C
`define OFF_M2_THERMAL_CURVE_SEL       16'h230D
`define OFF_M2_PARAM_SOURCE_SEL        16'h2502
`define OFF_M2_CAPACITY_SEL            16'h2503
`define OFF_M2_POLE_COUNT_SEL          16'h2504
`define OFF_M2_SPEED_RESPONSE_HI       16'h2505
`define OFF_M2_SPEED_RESPONSE_LO       16'h2506
`define OFF_M2_STABILIZATION           16'h2507
`define OFF_M2_PRIMARY_RES_HI          16'h2515
`define OFF_M2_PRIMARY_RES_LO          16'h2516
`define OFF_M2_SECONDARY_RES_HI        16'h2517
`define OFF_M2_SECONDARY_RES_LO        16'h2518
`define OFF_M2_INDUCTANCE_HI           16'h2519
`define OFF_M2_INDUCTANCE_LO           16'h251A
`define OFF_M2_NOLOAD_CURRENT_HI       16'h251B
`define OFF_M2_NOLOAD_CURRENT_LO       16'h251C
`define OFF_M2_INERTIA_HI              16'h251D
`define OFF_M2_INERTIA_LO              16'h251E
`define OFF_M2_TUNED_PRIMARY_RES_HI    16'h2524
`define OFF_M2_TUNED_PRIMARY_RES_LO    16'h2525
`define OFF_M2_TUNED_SECONDARY_RES_HI  16'h2526
`define OFF_M2_TUNED_SECONDARY_RES_LO  16'h2527
`define OFF_M2_TUNED_INDUCTANCE_HI     16'h2528
`define OFF_M2_TUNED_INDUCTANCE_LO     16'h2529
`define OFF_M2_TUNED_NOLOAD_CURRENT_HI 16'h252A
`define OFF_M2_TUNED_NOLOAD_CURRENT_LO 16'h252B
`define OFF_M2_TUNED_INERTIA_HI        16'h252C
`define OFF_M2_TUNED_INERTIA_LO        16'h252D
`define OFF_M2_PI_PROP_GAIN            16'h253D
`define OFF_M2_PI_INTEGRAL_GAIN        16'h253E
`define OFF_M2_P_PROP_GAIN             16'h253F
`define OFF_M2_ZERO_HZ_LIMIT           16'h2547
`define OFF_M2_STARTUP_BOOST           16'h2548
`define OFF_M3_ACCEL_TIME1_HI          16'h3103
`define OFF_M3_ACCEL_TIME1_LO          16'h3104
`define OFF_M3_DECEL_TIME1_HI          16'h3105
`define OFF_M3_DECEL_TIME1_LO          16'h3106

// ****************************************************************
// value limits
// ****************************************************************
`define LIM_THERMAL_MIN    32'h0000_00C8
`define LIM_THERMAL_MAX    32'h0000_03E8
`define LIM_CURVE_MAX      32'h0000_0002
`define LIM_SOURCE_MAX     32'h0000_0002
`define LIM_CAPACITY_MAX   32'h0000_001A
`define LIM_POLE_MAX       32'h0000_0004
`define LIM_SPEED_RESP_MAX 32'h0001_3880
`define LIM_STAB_MAX       32'h0000_00FF
`define LIM_CONST_MAX      32'h0000_FFFA
`define LIM_INERTIA_MAX    32'h0098_9298
`define LIM_PI_GAIN_MAX    32'h0000_2710
`define LIM_P_GAIN_MAX     32'h0000_03E8
`define LIM_ZERO_LIMIT_MAX 32'h0000_03E8
`define LIM_BOOST_MAX      32'h0000_0032
`define LIM_TIME_MAX       32'h0005_7E40
`define LIM_ONE            32'h0000_0001
`define LIM_ZERO           32'h0000_0000

// ****************************************************************
// reset values (smallest legal value of each parameter)
// ****************************************************************
`define RST_THERMAL        16'h00C8
`define RST_ONE            16'h0001
`define RST_ZERO           16'h0000

`endif

/* File: rtl/motor2_regs_pkg.sv */
// types of the second motor parameter bank
// assumes nothing of its surroundings
package motor2_regs_pkg;

	// index of each stored parameter; split values take one slot each
	typedef enum {
		P_THERMAL, P_CURVE, P_SOURCE, P_CAPACITY, P_POLES, P_SPEED_RESP, P_STAB,
		P_R1, P_R2, P_IND, P_NOLOAD, P_INERTIA,
		P_T_R1, P_T_R2, P_T_IND, P_T_NOLOAD, P_T_INERTIA,
		P_PI_P, P_PI_I, P_P_P, P_ZERO_LIMIT, P_BOOST, P_ACCEL, P_DECEL, P_COUNT
	} param_idx_t;

	typedef enum {
		WORD_SINGLE, WORD_HI, WORD_LO
	} word_part_t;

endpackage

/* File: rtl/second_motor_param_regs.sv */
// holding register bank: second motor parameters and third motor first ramp times
// assumes a host port with one-cycle strobes, read data one cycle after the read strobe
// How it works
// - thermal level accepts 200..1000, unit 0.1 percent of rated current
// - thermal curve code 0 reduced, 1 constant torque, 2 free curve
// - parameter source 0 standard, 1 tuned, 2 tuned with online tuning
// - capacity code 0..26; codes 1,3,5,8,10 are unused and refused
// - pole code 0..4 stands for 2,4,6,8,10 poles
// - wide values split: high word at lower address, low word next
// - primary and secondary resistance, manual and tuned, 1..65530 milliohm
// - leakage inductance, manual and tuned, 1..65530 in 0.01 mH
// - inertia, manual and tuned, 32-bit split 1..9999000
// - PI proportional gain 0..10000, unit 0.1 percent
// - PI integral gain 0..10000, unit 0.1 percent
// - P-only gain 0..1000, unit 0.01
// - startup boost at zero frequency 0..50 percent
// - third motor accel time 1 is split 1..360000, unit 0.01 s
// - third motor decel time 1 is split 1..360000, unit 0.01 s
//
// The implementer's own choice: the address-and-strobe port.
`include "motor2_regs_map.svh"

module second_motor_param_regs
	import motor2_regs_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_srst,
	input  wire logic [15:0] i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [15:0] o_rdata,
	output logic             o_wr_refused,
	output logic      [15:0] o_thermal_level,
	output logic      [1:0]  o_thermal_curve,
	output logic      [1:0]  o_param_source,
	output logic      [4:0]  o_capacity,
	output logic      [2:0]  o_pole_code,
	output logic      [31:0] o_speed_response,
	output logic      [7:0]  o_stabilization,
	output logic      [31:0] o_active_primary_res,
	output logic      [31:0] o_active_secondary_res,
	output logic      [31:0] o_active_inductance,
	output logic      [31:0] o_active_noload_current,
	output logic      [31:0] o_active_inertia,
	output logic      [15:0] o_pi_prop_gain,
	output logic      [15:0] o_pi_integral_gain,
	output logic      [15:0] o_p_prop_gain,
	output logic      [15:0] o_zero_hz_limit,
	output logic      [7:0]  o_startup_boost,
	output logic      [31:0] o_accel_time1,
	output logic      [31:0] o_decel_time1
);

	localparam int NPAR = int'(P_COUNT);

	// ****************************************************************
	// address decode
	// ****************************************************************
	typedef struct packed {
		logic       hit;
		logic [4:0] idx;
		logic [1:0] part;
	} decode_t;

	function automatic decode_t decode(input logic [15:0] a);
		decode_t d;
		d = '{hit: 1'b1, idx: 5'h00, part: 2'(WORD_SINGLE)};
		case (a)
			`OFF_M2_THERMAL_LEVEL:           d.idx = 5'(P_THERMAL);
			`OFF_M2_THERMAL_CURVE_SEL:       d.idx = 5'(P_CURVE);
			`OFF_M2_PARAM_SOURCE_SEL:        d.idx = 5'(P_SOURCE);
			`OFF_M2_CAPACITY_SEL:            d.idx = 5'(P_CAPACITY);
			`OFF_M2_POLE_COUNT_SEL:          d.idx = 5'(P_POLES);
			`OFF_M2_STABILIZATION:           d.idx = 5'(P_STAB);
			`OFF_M2_PI_PROP_GAIN:            d.idx = 5'(P_PI_P);
			`OFF_M2_PI_INTEGRAL_GAIN:        d.idx = 5'(P_PI_I);
			`OFF_M2_P_PROP_GAIN:             d.idx = 5'(P_P_P);
			`OFF_M2_ZERO_HZ_LIMIT:           d.idx = 5'(P_ZERO_LIMIT);
			`OFF_M2_STARTUP_BOOST:           d.idx = 5'(P_BOOST);
			`OFF_M2_SPEED_RESPONSE_HI:       d = '{1'b1, 5'(P_SPEED_RESP), 2'(WORD_HI)};
			`OFF_M2_SPEED_RESPONSE_LO:       d = '{1'b1, 5'(P_SPEED_RESP), 2'(WORD_LO)};
			`OFF_M2_PRIMARY_RES_HI:          d = '{1'b1, 5'(P_R1), 2'(WORD_HI)};
			`OFF_M2_PRIMARY_RES_LO:          d = '{1'b1, 5'(P_R1), 2'(WORD_LO)};
			`OFF_M2_SECONDARY_RES_HI:        d = '{1'b1, 5'(P_R2), 2'(WORD_HI)};
			`OFF_M2_SECONDARY_RES_LO:        d = '{1'b1, 5'(P_R2), 2'(WORD_LO)};
			`OFF_M2_INDUCTANCE_HI:           d = '{1'b1, 5'(P_IND), 2'(WORD_HI)};
			`OFF_M2_INDUCTANCE_LO:           d = '{1'b1, 5'(P_IND), 2'(WORD_LO)};
			`OFF_M2_NOLOAD_CURRENT_HI:       d = '{1'b1, 5'(P_NOLOAD), 2'(WORD_HI)};
			`OFF_M2_NOLOAD_CURRENT_LO:       d = '{1'b1, 5'(P_NOLOAD), 2'(WORD_LO)};
			`OFF_M2_INERTIA_HI:              d = '{1'b1, 5'(P_INERTIA), 2'(WORD_HI)};
			`OFF_M2_INERTIA_LO:              d = '{1'b1, 5'(P_INERTIA), 2'(WORD_LO)};
			`OFF_M2_TUNED_PRIMARY_RES_HI:    d = '{1'b1, 5'(P_T_R1), 2'(WORD_HI)};
			`OFF_M2_TUNED_PRIMARY_RES_LO:    d = '{1'b1, 5'(P_T_R1), 2'(WORD_LO)};
			`OFF_M2_TUNED_SECONDARY_RES_HI:  d = '{1'b1, 5'(P_T_R2), 2'(WORD_HI)};
			`OFF_M2_TUNED_SECONDARY_RES_LO:  d = '{1'b1, 5'(P_T_R2), 2'(WORD_LO)};
			`OFF_M2_TUNED_INDUCTANCE_HI:     d = '{1'b1, 5'(P_T_IND), 2'(WORD_HI)};
			`OFF_M2_TUNED_INDUCTANCE_LO:     d = '{1'b1, 5'(P_T_IND), 2'(WORD_LO)};
			`OFF_M2_TUNED_NOLOAD_CURRENT_HI: d = '{1'b1, 5'(P_T_NOLOAD), 2'(WORD_HI)};
			`OFF_M2_TUNED_NOLOAD_CURRENT_LO: d = '{1'b1, 5'(P_T_NOLOAD), 2'(WORD_LO)};
			`OFF_M2_TUNED_INERTIA_HI:        d = '{1'b1, 5'(P_T_INERTIA), 2'(WORD_HI)};
			`OFF_M2_TUNED_INERTIA_LO:        d = '{1'b1, 5'(P_T_INERTIA), 2'(WORD_LO)};
			`OFF_M3_ACCEL_TIME1_HI:          d = '{1'b1, 5'(P_ACCEL), 2'(WORD_HI)};
			`OFF_M3_ACCEL_TIME1_LO:          d = '{1'b1, 5'(P_ACCEL), 2'(WORD_LO)};
			`OFF_M3_DECEL_TIME1_HI:          d = '{1'b1, 5'(P_DECEL), 2'(WORD_HI)};
			`OFF_M3_DECEL_TIME1_LO:          d = '{1'b1, 5'(P_DECEL), 2'(WORD_LO)};
			default:                         d.hit = 1'b0;
		endcase
		return d;
	endfunction

	// ****************************************************************
	// legal range of each parameter
	// ****************************************************************
	function automatic logic [31:0] lim_min(input logic [4:0] i);
		case (i)
			5'(P_THERMAL):                                               lim_min = `LIM_THERMAL_MIN;
			5'(P_SPEED_RESP),
			5'(P_R1),
			5'(P_R2),
			5'(P_IND),
			5'(P_NOLOAD),
			5'(P_T_R1),
			5'(P_T_R2),
			5'(P_T_IND),
			5'(P_T_NOLOAD),
			5'(P_INERTIA),
			5'(P_T_INERTIA),
			5'(P_ACCEL),
			5'(P_DECEL):                                                 lim_min = `LIM_ONE;
			default:                                                     lim_min = `LIM_ZERO;
		endcase
	endfunction

	function automatic logic [31:0] lim_max(input logic [4:0] i);
		case (i)
			5'(P_THERMAL):                        lim_max = `LIM_THERMAL_MAX;
			5'(P_CURVE):                          lim_max = `LIM_CURVE_MAX;
			5'(P_SOURCE):                         lim_max = `LIM_SOURCE_MAX;
			5'(P_CAPACITY):                       lim_max = `LIM_CAPACITY_MAX;
			5'(P_POLES):                          lim_max = `LIM_POLE_MAX;
			5'(P_SPEED_RESP):                     lim_max = `LIM_SPEED_RESP_MAX;
			5'(P_STAB):                           lim_max = `LIM_STAB_MAX;
			5'(P_R1), 5'(P_R2), 5'(P_T_R1),
			5'(P_T_R2), 5'(P_NOLOAD),
			5'(P_T_NOLOAD):                       lim_max = `LIM_CONST_MAX;
			5'(P_IND), 5'(P_T_IND):               lim_max = `LIM_CONST_MAX;
			5'(P_INERTIA), 5'(P_T_INERTIA):       lim_max = `LIM_INERTIA_MAX;
			5'(P_PI_P):                           lim_max = `LIM_PI_GAIN_MAX;
			5'(P_PI_I):                           lim_max = `LIM_PI_GAIN_MAX;
			5'(P_P_P):                            lim_max = `LIM_P_GAIN_MAX;
			5'(P_ZERO_LIMIT):                     lim_max = `LIM_ZERO_LIMIT_MAX;
			5'(P_BOOST):                          lim_max = `LIM_BOOST_MAX;
			5'(P_ACCEL), 5'(P_DECEL):             lim_max = `LIM_TIME_MAX;
			default:                              lim_max = `LIM_ZERO;
		endcase
	endfunction

	function automatic logic [15:0] rst_val(input int i);
		case (i)
			int'(P_THERMAL):                                                 rst_val = `RST_THERMAL;
			int'(P_SPEED_RESP),
			int'(P_R1),
			int'(P_R2),
			int'(P_IND),
			int'(P_NOLOAD),
			int'(P_INERTIA),
			int'(P_T_R1),
			int'(P_T_R2),
			int'(P_T_IND),
			int'(P_T_NOLOAD),
			int'(P_T_INERTIA),
			int'(P_ACCEL),
			int'(P_DECEL):                                                   rst_val = `RST_ONE;
			default:                                                         rst_val = `RST_ZERO;
		endcase
	endfunction

	// capacity codes that carry no rating
	function automatic logic cap_unused(input logic [15:0] v);
		case (v)
			16'h0001, 16'h0003, 16'h0005, 16'h0008, 16'h000A: cap_unused = 1'b1;
			default:                                          cap_unused = 1'b0;
		endcase
	endfunction

	// ****************************************************************
	// write path
	// ****************************************************************
	logic [31:0] param_reg [NPAR];
	logic [15:0] hi_stage_reg;
	decode_t     wdec;
	logic [31:0] wval;
	logic        wlegal;

	// high word waits in a stage; the value commits whole with its low word
	always_comb begin
		wdec = decode(i_addr);
	end

	always_comb begin
		wval = {16'h0000, i_wdata};
		if (wdec.part == 2'(WORD_LO)) begin
			wval = {hi_stage_reg, i_wdata};
		end
	end

	// high words are only staged, so they are never refused
	always_comb begin
		wlegal = (wval >= lim_min(wdec.idx)) && (wval <= lim_max(wdec.idx));
		if (wdec.idx == 5'(P_CAPACITY) && cap_unused(i_wdata)) begin
			wlegal = 1'b0;
		end
		if (wdec.part == 2'(WORD_HI)) begin
			wlegal = 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			hi_stage_reg <= 16'h0000;
		end else if (i_wr && wdec.hit && wdec.part == 2'(WORD_HI)) begin
			hi_stage_reg <= i_wdata;
		end
	end

	generate
		for (genvar g = 0; g < NPAR; g++) begin : g_param
			always_ff @(posedge i_sys_clk) begin
				if (i_srst) begin
					param_reg[g] <= {16'h0000, rst_val(g)};
				end else if (i_wr && wdec.hit && wlegal && wdec.part != 2'(WORD_HI) && wdec.idx == 5'(g)) begin
					param_reg[g] <= wval;
				end
			end
		end
	endgenerate

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_wr_refused <= 1'b0;
		end else begin
			o_wr_refused <= i_wr && wdec.hit && !wlegal;
		end
	end

	// ****************************************************************
	// read path
	// ****************************************************************
	decode_t rdec;

	always_comb begin
		rdec = decode(i_addr);
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_rdata <= 16'h0000;
		end else if (i_rd && rdec.hit) begin
			if (rdec.part == 2'(WORD_HI)) begin
				o_rdata <= param_reg[rdec.idx][31:16];
			end else begin
				o_rdata <= param_reg[rdec.idx][15:0];
			end
		end else begin
			o_rdata <= 16'h0000;
		end
	end

	// ****************************************************************
	// parameter outputs
	// ****************************************************************
	logic use_tuned;

	always_comb begin
		use_tuned = (param_reg[P_SOURCE] != 32'h0000_0000);
	end

	// ****************************************************************
	// active constant set
	// ****************************************************************

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_active_primary_res <= 32'h0000_0001;
		end else begin
			o_active_primary_res <= use_tuned ? param_reg[P_T_R1] : param_reg[P_R1];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_active_secondary_res <= 32'h0000_0001;
		end else begin
			o_active_secondary_res <= use_tuned ? param_reg[P_T_R2] : param_reg[P_R2];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_active_inductance <= 32'h0000_0001;
		end else begin
			o_active_inductance <= use_tuned ? param_reg[P_T_IND] : param_reg[P_IND];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_active_noload_current <= 32'h0000_0001;
		end else begin
			o_active_noload_current <= use_tuned ? param_reg[P_T_NOLOAD] : param_reg[P_NOLOAD];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_active_inertia <= 32'h0000_0001;
		end else begin
			o_active_inertia <= use_tuned ? param_reg[P_T_INERTIA] : param_reg[P_INERTIA];
		end
	end

	always_comb begin
		o_thermal_level    = param_reg[P_THERMAL][15:0];
		o_thermal_curve    = param_reg[P_CURVE][1:0];
		o_param_source     = param_reg[P_SOURCE][1:0];
		o_capacity         = param_reg[P_CAPACITY][4:0];
		o_pole_code        = param_reg[P_POLES][2:0];
		o_speed_response   = param_reg[P_SPEED_RESP];
		o_stabilization    = param_reg[P_STAB][7:0];
	end

	always_comb begin
		o_pi_prop_gain     = param_reg[P_PI_P][15:0];
		o_pi_integral_gain = param_reg[P_PI_I][15:0];
		o_p_prop_gain      = param_reg[P_P_P][15:0];
		o_zero_hz_limit    = param_reg[P_ZERO_LIMIT][15:0];
		o_startup_boost    = param_reg[P_BOOST][7:0];
	end

	always_comb begin
		o_accel_time1      = param_reg[P_ACCEL];
		o_decel_time1      = param_reg[P_DECEL];
	end

endmodule
